// [hdl/via_arbiter.v]
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "via_defs.vh"
// Functional notes
// - 38 sources: 9 events, 7 soft, 5 exceptions plus reset, 16 traps.
// - Event taken only if global enable and its own enable set.
// - 3-bit priority; effective is field with top bit set, zero stays.
// - Equal priority requests resolved by fixed rank, zero highest.
// - All resets use vector 0000 with rank zero.
// - Hardware traps vectors 0004..0014, rank one.
// - Sixteen trap instructions use vectors 0040..007C, rank one.
// - External, timer event vectors 0080..0090 with ranks 2..6.
// - Serial event vectors 00A0..00AC with ranks 7..10.
// - Priority registers hold two 3-bit fields, bits 2-0 and 6-4, except PRI2 with bits 2-0 only.
// - Software interrupts 1..7 raised by request bits, fixed priority.
module via_arbiter (
	input wire ref_clk, // Core clock 50 MHz
	input wire rst, // Async reset, active high
	input wire [3:0] avs_address, // Word address
	input wire avs_read, // Read strobe
	input wire avs_write, // Write strobe
	input wire [31:0] avs_writedata, // Write data
	output reg [31:0] avs_readdata, // Read data
	output wire avs_waitrequest, // Wait request
	input wire reset_req, // Reset request, core clock
	input wire [4:0] hw_trap_req, // Brk, trace, stkovf, div0, user ret
	input wire trap_req, // Trap instruction strobe
	input wire [3:0] trap_num, // Trap number 0..15
	input wire ext_input0_pin, // External input 0, async
	input wire ext_input1_pin, // External input 1, async
	input wire timer0_overflow_flag, // Timer 0 request
	input wire timer1_overflow_flag, // Timer 1 request
	input wire timer2_event_flag, // Timer 2 request
	input wire serial0_rx_flag, // Serial 0 receive
	input wire serial0_tx_flag, // Serial 0 transmit
	input wire serial1_rx_flag, // Serial 1 receive
	input wire serial1_tx_flag, // Serial 1 transmit
	output reg irq_valid, // Request to core
	output reg [15:0] irq_vector, // Vector address
	output reg [3:0] irq_priority, // Priority of request
	input wire irq_ack, // Core accepts vector
	output wire irq_out // Status interrupt
);
	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] enl_ff;
	reg [7:0] enh_ff;
	reg [6:0] pri0_ff;
	reg [6:0] pri1_ff;
	reg [6:0] pri2_ff;
	reg [6:0] pri4_ff;
	reg [6:0] pri5_ff;
	reg [7:1] swr_ff;
	reg [7:1] swe_ff;
	reg [3:0] cur_pri_ff;
	reg [2:0] stat_ff;
	reg [2:0] mask_ff;
	reg ack_done_ff;
	wire ext0_sync;
	wire ext1_sync;
	reg ext0_prev_ff;
	reg ext1_prev_ff;
	reg ext_input0_flag_ff;
	reg ext_input1_flag_ff;
	reg trap_pend_ff;
	reg [3:0] trap_num_ff;
	reg rd_ok_ff;
	wire rd_cap;
	reg pres_is_evt_ff;
	reg [3:0] pres_evt_ff;
	reg pres_is_trap_ff;
	reg pres_is_hw_ff;
	reg pres_is_sw_ff;
	wire [3:0] eff [0:8];
	wire [2:0] fld [0:8];
	wire [8:0] evt_flag;
	wire [8:0] evt_en;
	wire [15:0] evt_vec [0:8];
	wire global_event_enable;
	assign global_event_enable = enl_ff[`VIA_ENL_GLOBAL];
	// ****************************************
	// Bus handshake
	// ****************************************
	// Reads wait one cycle for registered data
	assign rd_cap = avs_read && !rd_ok_ff;
	assign avs_waitrequest = rd_cap;
	// ****************************************
	// Pin synchronisers and edge capture
	// ****************************************
	via_sync3 u_sync0 (
		.ref_clk(ref_clk),
		.rst(rst),
		.d(ext_input0_pin),
		.q(ext0_sync)
	);
	via_sync3 u_sync1 (
		.ref_clk(ref_clk),
		.rst(rst),
		.d(ext_input1_pin),
		.q(ext1_sync)
	);
	// ****************************************
	// Event table
	// ****************************************
	// nine event sources
	assign evt_flag = {serial1_tx_flag, serial1_rx_flag, serial0_tx_flag, serial0_rx_flag,
		timer2_event_flag, timer1_overflow_flag, ext_input1_flag_ff, timer0_overflow_flag,
		ext_input0_flag_ff};
	assign evt_en = {enh_ff[3:0], enl_ff[4:0]};
	assign fld[0] = pri0_ff[2:0];
	assign fld[1] = pri0_ff[6:4];
	assign fld[2] = pri1_ff[2:0];
	assign fld[3] = pri1_ff[6:4];
	assign fld[4] = pri2_ff[2:0];
	assign fld[5] = pri4_ff[2:0];
	assign fld[6] = pri4_ff[6:4];
	assign fld[7] = pri5_ff[2:0];
	assign fld[8] = pri5_ff[6:4];
	assign evt_vec[0] = `VIA_VEC_EXT0;
	assign evt_vec[1] = `VIA_VEC_TMR0;
	assign evt_vec[2] = `VIA_VEC_EXT1;
	assign evt_vec[3] = `VIA_VEC_TMR1;
	assign evt_vec[4] = `VIA_VEC_TMR2;
	assign evt_vec[5] = `VIA_VEC_S0RX;
	assign evt_vec[6] = `VIA_VEC_S0TX;
	assign evt_vec[7] = `VIA_VEC_S1RX;
	assign evt_vec[8] = `VIA_VEC_S1TX;
	genvar gi;
	generate
		for (gi = 0; gi < `VIA_NUM_EVT; gi = gi + 1) begin : g_pri
			via_prio_map u_map (
				.field(fld[gi]),
				.eff(eff[gi])
			);
		end
	endgenerate
	// ****************************************
	// Arbitration
	// ****************************************
	reg sel_valid;
	reg [15:0] sel_vec;
	reg [3:0] sel_pri;
	reg sel_is_trap;
	reg sel_is_hw;
	reg sel_is_evt;
	reg [3:0] sel_evt;
	reg sel_is_sw;
	integer i;
	always @* begin
		sel_valid = 1'b0;
		sel_vec = 16'h0000;
		sel_pri = 4'h0;
		sel_is_trap = 1'b0;
		sel_is_hw = 1'b0;
		sel_is_evt = 1'b0;
		sel_evt = 4'h0;
		sel_is_sw = 1'b0;
		// rank order; higher priority strictly replaces
		if (reset_req) begin
			sel_valid = 1'b1;
			sel_vec = `VIA_VEC_RESET;
			sel_pri = `VIA_EXC_PRI;
		end else if (hw_trap_req != 5'h00) begin
			sel_valid = 1'b1;
			sel_pri = `VIA_EXC_PRI;
			sel_is_hw = 1'b1;
			if (hw_trap_req[0]) begin
				sel_vec = `VIA_VEC_BRK;
			end else if (hw_trap_req[1]) begin
				sel_vec = `VIA_VEC_TRACE;
			end else if (hw_trap_req[2]) begin
				sel_vec = `VIA_VEC_STKOVF;
			end else if (hw_trap_req[3]) begin
				sel_vec = `VIA_VEC_DIV0;
			end else begin
				sel_vec = `VIA_VEC_URETI;
			end
		end else if (trap_pend_ff) begin
			sel_valid = 1'b1;
			sel_pri = `VIA_EXC_PRI;
			sel_is_trap = 1'b1;
			sel_vec = `VIA_VEC_TRAP + {10'h000, trap_num_ff, 2'b00};
		end else begin
			for (i = 0; i < `VIA_NUM_EVT; i = i + 1) begin
				// zero never taken, must beat running level
				if (global_event_enable && evt_en[i] && evt_flag[i] && eff[i] != 4'h0 &&
					eff[i] > cur_pri_ff && (!sel_valid || eff[i] > sel_pri)) begin
					sel_valid = 1'b1;
					sel_pri = eff[i];
					sel_vec = evt_vec[i];
					sel_is_evt = 1'b1;
					sel_evt = i[3:0];
				end
			end
			for (i = 1; i < 8; i = i + 1) begin
				if (swr_ff[i] && swe_ff[i] && i[3:0] > cur_pri_ff &&
					(!sel_valid || i[3:0] > sel_pri)) begin
					sel_valid = 1'b1;
					sel_pri = i[3:0];
					sel_vec = `VIA_VEC_SWI + {11'h000, i[2:0] - 3'h1, 2'b00};
					sel_is_evt = 1'b0;
					sel_is_sw = 1'b1;
				end
			end
		end
	end
	// ****************************************
	// Core request, sticky status, bus
	// ****************************************
	wire rd_stat;
	wire take;
	assign rd_stat = rd_cap && avs_address == `VIA_OFF_STAT;
	// Ack honoured once per presentation
	assign take = irq_valid && irq_ack && !ack_done_ff;
	// Level interrupt from sticky status
	assign irq_out = |(stat_ff & mask_ff);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			enl_ff <= 8'h00;
			enh_ff <= 8'h00;
			pri0_ff <= 7'h00;
			pri1_ff <= 7'h00;
			pri2_ff <= 7'h00;
			pri4_ff <= 7'h00;
			pri5_ff <= 7'h00;
			swr_ff <= 7'h00;
			swe_ff <= 7'h00;
			cur_pri_ff <= 4'h0;
			stat_ff <= 3'h0;
			mask_ff <= 3'h0;
			rd_ok_ff <= 1'b0;
			ext0_prev_ff <= 1'b0;
			ext1_prev_ff <= 1'b0;
			ext_input0_flag_ff <= 1'b0;
			ext_input1_flag_ff <= 1'b0;
			trap_pend_ff <= 1'b0;
			trap_num_ff <= 4'h0;
			avs_readdata <= 32'h00000000;
		end else begin
			rd_ok_ff <= rd_cap;
			ext0_prev_ff <= ext0_sync;
			ext1_prev_ff <= ext1_sync;
			// External edge flags; set wins over acknowledge
			if (ext0_sync && !ext0_prev_ff) begin
				ext_input0_flag_ff <= 1'b1;
			end else if (take && pres_is_evt_ff && pres_evt_ff == 4'h0) begin
				ext_input0_flag_ff <= 1'b0;
			end
			if (ext1_sync && !ext1_prev_ff) begin
				ext_input1_flag_ff <= 1'b1;
			end else if (take && pres_is_evt_ff && pres_evt_ff == 4'h2) begin
				ext_input1_flag_ff <= 1'b0;
			end
			if (trap_req) begin
				trap_pend_ff <= 1'b1;
				trap_num_ff <= trap_num;
			end else if (take && pres_is_trap_ff) begin
				trap_pend_ff <= 1'b0;
			end
			if (take) begin
				cur_pri_ff <= irq_priority;
			end
			// Status: bit0 taken, bit1 exception, bit2 software
			stat_ff <= (rd_stat ? 3'h0 : stat_ff) |
				{take && pres_is_sw_ff, take && (pres_is_hw_ff || pres_is_trap_ff), take};
			if (avs_write) begin
				case (avs_address)
					`VIA_OFF_ENL: enl_ff <= avs_writedata[7:0];
					`VIA_OFF_ENH: enh_ff <= avs_writedata[7:0];
					`VIA_OFF_PRI0: pri0_ff <= avs_writedata[6:0] & `VIA_PRI_PAIR_MASK;
					`VIA_OFF_PRI1: pri1_ff <= avs_writedata[6:0] & `VIA_PRI_PAIR_MASK;
					`VIA_OFF_PRI2: pri2_ff <= avs_writedata[6:0] & `VIA_PRI_ONE_MASK;
					`VIA_OFF_PRI4: pri4_ff <= avs_writedata[6:0] & `VIA_PRI_PAIR_MASK;
					`VIA_OFF_PRI5: pri5_ff <= avs_writedata[6:0] & `VIA_PRI_PAIR_MASK;
					`VIA_OFF_SWR: swr_ff <= avs_writedata[7:1];
					`VIA_OFF_SWE: swe_ff <= avs_writedata[7:1];
					`VIA_OFF_CUR: cur_pri_ff <= avs_writedata[3:0];
					`VIA_OFF_MASK: mask_ff <= avs_writedata[2:0];
					default: ;
				endcase
			end
			avs_readdata <= 32'h00000000;
			if (rd_cap) begin
				case (avs_address)
					`VIA_OFF_ENL: avs_readdata <= {24'h000000, enl_ff};
					`VIA_OFF_ENH: avs_readdata <= {24'h000000, enh_ff};
					`VIA_OFF_PRI0: avs_readdata <= {25'h0000000, pri0_ff};
					`VIA_OFF_PRI1: avs_readdata <= {25'h0000000, pri1_ff};
					`VIA_OFF_PRI2: avs_readdata <= {25'h0000000, pri2_ff};
					`VIA_OFF_PRI4: avs_readdata <= {25'h0000000, pri4_ff};
					`VIA_OFF_PRI5: avs_readdata <= {25'h0000000, pri5_ff};
					`VIA_OFF_SWR: avs_readdata <= {24'h000000, swr_ff, 1'b0};
					`VIA_OFF_SWE: avs_readdata <= {24'h000000, swe_ff, 1'b0};
					`VIA_OFF_CUR: avs_readdata <= {28'h0000000, cur_pri_ff};
					`VIA_OFF_STAT: avs_readdata <= {29'h00000000, stat_ff};
					`VIA_OFF_MASK: avs_readdata <= {29'h00000000, mask_ff};
					`VIA_OFF_VEC: avs_readdata <= {16'h0000, irq_vector};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end
	// ****************************************
	// Presentation to core
	// ****************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_valid <= 1'b0;
			irq_vector <= 16'h0000;
			irq_priority <= 4'h0;
			ack_done_ff <= 1'b0;
			pres_is_evt_ff <= 1'b0;
			pres_evt_ff <= 4'h0;
			pres_is_trap_ff <= 1'b0;
			pres_is_hw_ff <= 1'b0;
			pres_is_sw_ff <= 1'b0;
		end else begin
			// drop for a cycle after take
			irq_valid <= sel_valid && !take;
			irq_vector <= sel_vec;
			irq_priority <= sel_pri;
			ack_done_ff <= take;
			// Take acts on the source shown, not a newer one
			pres_is_evt_ff <= sel_is_evt;
			pres_evt_ff <= sel_evt;
			pres_is_trap_ff <= sel_is_trap;
			pres_is_hw_ff <= sel_is_hw;
			pres_is_sw_ff <= sel_is_sw;
		end
	end
endmodule // via_arbiter

// [hdl/via_defs.vh]
`ifndef VIA_DEFS_VH
`define VIA_DEFS_VH
// Register word offsets
`define VIA_OFF_ENL 4'h0
`define VIA_OFF_ENH 4'h1
`define VIA_OFF_PRI0 4'h2
`define VIA_OFF_PRI1 4'h3
`define VIA_OFF_PRI2 4'h4
`define VIA_OFF_PRI4 4'h5
`define VIA_OFF_PRI5 4'h6
`define VIA_OFF_SWR 4'h7
`define VIA_OFF_SWE 4'h8
`define VIA_OFF_CUR 4'h9
`define VIA_OFF_STAT 4'ha
`define VIA_OFF_MASK 4'hb
`define VIA_OFF_VEC 4'hc
// Enable register fields
`define VIA_ENL_GLOBAL 7
// Vector addresses
`define VIA_VEC_RESET 16'h0000
`define VIA_VEC_BRK 16'h0004
`define VIA_VEC_TRACE 16'h0008
`define VIA_VEC_STKOVF 16'h000c
`define VIA_VEC_DIV0 16'h0010
`define VIA_VEC_URETI 16'h0014
`define VIA_VEC_TRAP 16'h0040
`define VIA_VEC_SWI 16'h0100
`define VIA_VEC_EXT0 16'h0080
`define VIA_VEC_TMR0 16'h0084
`define VIA_VEC_EXT1 16'h0088
`define VIA_VEC_TMR1 16'h008c
`define VIA_VEC_TMR2 16'h0090
`define VIA_VEC_S0RX 16'h00a0
`define VIA_VEC_S0TX 16'h00a4
`define VIA_VEC_S1RX 16'h00a8
`define VIA_VEC_S1TX 16'h00ac
// Priority field layout
`define VIA_PRI_LO 2
`define VIA_PRI_HI_LSB 4
`define VIA_PRI_PAIR_MASK 7'h77
`define VIA_PRI_ONE_MASK 7'h07
`define VIA_EXC_PRI 4'hf
`define VIA_NUM_EVT 9
`define VIA_NUM_SRC 38
`endif

// [hdl/via_prio_map.v]
`timescale 1ns/1ns
`include "via_defs.vh"
// ****************************************
// Effective event priority
// ****************************************
module via_prio_map (
	input wire [2:0] field, // 3-bit programmed level
	output wire [3:0] eff // 4-bit effective level
);
	assign eff = (field == 3'h0) ? 4'h0 : {1'b1, field};
endmodule // via_prio_map

// [hdl/via_sync3.v]
`timescale 1ns/1ns
// ****************************************
// Three-stage input synchroniser
// ****************************************
module via_sync3 (
	input wire ref_clk, // Core clock
	input wire rst, // Async reset
	input wire d, // Asynchronous level
	output reg q // Filtered level
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				q <= s3_ff;
			end
		end
	end
endmodule // via_sync3

// [verif/vectored_interrupt_arbiter_test.sv]
`timescale 1ns/1ns
`include "via_defs.vh"
module vectored_interrupt_arbiter_test;
	// ********
	// Stimulus and checks
	// ********
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg [3:0] avs_address = 4'h0;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	reg reset_req = 1'b0;
	reg [4:0] hw_trap_req = 5'h00;
	reg trap_req = 1'b0;
	reg [3:0] trap_num = 4'h0;
	reg [1:0] ext = 2'h0;
	reg [6:0] lvl = 7'h00;
	reg [3:0] lat = 4'h0;
	reg [31:0] rdat;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire irq_valid;
	wire [15:0] irq_vector;
	wire [3:0] irq_priority;
	wire irq_ack;
	wire irq_out;
	integer errors = 0;
	integer checks = 0;
	integer i;
	localparam logic [15:0] lvec [0:6] = '{16'h0084, 16'h008c, 16'h0090, 16'h00a0,
		16'h00a4, 16'h00a8, 16'h00ac};
	always #10 ref_clk = ~ref_clk;
	via_arbiter u_via_arbiter (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .reset_req, .hw_trap_req,
		.trap_req, .trap_num, .ext_input0_pin(ext[0]), .ext_input1_pin(ext[1]),
		.timer0_overflow_flag(lvl[0]), .timer1_overflow_flag(lvl[1]),
		.timer2_event_flag(lvl[2]), .serial0_rx_flag(lvl[3]), .serial0_tx_flag(lvl[4]),
		.serial1_rx_flag(lvl[5]), .serial1_tx_flag(lvl[6]), .irq_valid, .irq_vector,
		.irq_priority, .irq_ack, .irq_out);
	via_core_model u_via_core_model (.ref_clk, .rst, .irq_valid, .lat, .irq_ack);
	task end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string w, input logic [31:0] e, input logic [31:0] g);
		checks = checks + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask
	task tmo;
		chk("wait", 0, 1);
		end_sim;
	endtask
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		integer n;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			n = n + 1;
			if (n > 50)
				tmo;
			@(posedge ref_clk);
		end
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input string w);
		bus(1'b0, a, 32'h0);
		chk(w, e, rdat);
	endtask
	task irq(input logic [15:0] v, input logic [3:0] p);
		integer n;
		n = 0;
		while (irq_valid !== 1'b1) begin
			n = n + 1;
			if (n > 60)
				tmo;
			@(posedge ref_clk);
		end
		chk("irq_vector", v, irq_vector);
		chk("irq_priority", p, irq_priority);
		while (irq_ack !== 1'b1) begin
			n = n + 1;
			if (n > 80)
				tmo;
			@(posedge ref_clk);
		end
		// Core accepted: exception sources drop, stale valid passes
		hw_trap_req <= 5'h00;
		reset_req <= 1'b0;
		@(posedge ref_clk);
	endtask
	task quiet;
		repeat (8) begin
			@(posedge ref_clk);
			chk("irq_valid", 0, irq_valid);
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		rd(4'h0, 32'h0, "enl");
		bus(1'b1, 4'hd, 32'hff);
		rd(4'hd, 32'h0, "unmapped");
		bus(1'b1, 4'h2, 32'hff);
		rd(4'h2, 32'h77, "pri0");
		$display("test registers done");
		for (i = 2; i < 7; i = i + 1)
			bus(1'b1, i[3:0], 32'h33);
		bus(1'b1, 4'h0, 32'h9f);
		bus(1'b1, 4'h1, 32'h0f);
		bus(1'b1, 4'hb, 32'h07);
		lvl <= 7'h7f;
		for (i = 0; i < 7; i = i + 1) begin
			irq(lvec[i], 4'hb);
			lvl[i] <= 1'b0;
			bus(1'b1, 4'h9, 32'h0);
		end
		chk("irq_out", 1, irq_out);
		bus(1'b1, 4'hb, 32'h0);
		chk("irq_out", 0, irq_out);
		bus(1'b1, 4'hb, 32'h07);
		rd(4'ha, 32'h1, "status");
		chk("irq_out", 0, irq_out);
		$display("test rank done");
		bus(1'b1, 4'h3, 32'h36);
		bus(1'b1, 4'h0, 32'h1f);
		ext[1] <= 1'b1;
		lvl[0] <= 1'b1;
		quiet;
		bus(1'b1, 4'h0, 32'h9f);
		irq(16'h0088, 4'he);
		ext[1] <= 1'b0;
		bus(1'b1, 4'h9, 32'h0);
		irq(16'h0084, 4'hb);
		lvl[0] <= 1'b0;
		bus(1'b1, 4'h2, 32'h30);
		bus(1'b1, 4'h9, 32'h0);
		ext[0] <= 1'b1;
		quiet;
		bus(1'b1, 4'h2, 32'h32);
		irq(16'h0080, 4'ha);
		ext[0] <= 1'b0;
		bus(1'b1, 4'h0, 32'h9d);
		lvl[0] <= 1'b1;
		quiet;
		bus(1'b1, 4'h9, 32'h0b);
		bus(1'b1, 4'h0, 32'h9f);
		quiet;
		bus(1'b1, 4'h9, 32'h0a);
		irq(16'h0084, 4'hb);
		lvl[0] <= 1'b0;
		bus(1'b1, 4'h9, 32'h0);
		$display("test enables done");
		bus(1'b1, 4'h8, 32'hfe);
		for (i = 1; i < 8; i = i + 1) begin
			bus(1'b1, 4'h7, 32'h1 << i);
			irq(16'h00fc + 16'(4 * i), i[3:0]);
			bus(1'b1, 4'h7, 32'h0);
			bus(1'b1, 4'h9, 32'h0);
		end
		$display("test soft done");
		lat <= 4'h3;
		bus(1'b1, 4'h9, 32'hf);
		for (i = 0; i < 5; i = i + 1) begin
			hw_trap_req <= 5'h01 << i;
			irq(16'h0004 + 16'(4 * i), 4'hf);
		end
		hw_trap_req <= 5'h00;
		for (i = 0; i < 16; i = i + 1) begin
			trap_num <= i[3:0];
			trap_req <= 1'b1;
			@(posedge ref_clk);
			trap_req <= 1'b0;
			irq(16'h0040 + 16'(4 * i), 4'hf);
		end
		hw_trap_req <= 5'h1f;
		reset_req <= 1'b1;
		irq(16'h0000, 4'hf);
		hw_trap_req <= 5'h00;
		reset_req <= 1'b0;
		rd(4'ha, 32'h7, "status");
		rd(4'h9, 32'hf, "cur");
		$display("test exceptions done");
		end_sim;
	end
endmodule // vectored_interrupt_arbiter_test

// [verif/via_core_model.sv]
`timescale 1ns/1ns
// ********
// Core side acceptor
// ********
module via_core_model (
	input wire ref_clk, // Core clock
	input wire rst, // Async reset
	input wire irq_valid, // Request from arbiter
	input wire [3:0] lat, // Accept delay
	output reg irq_ack // Accept pulse
);
	reg [3:0] wait_ff;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_ack <= 1'b0;
			wait_ff <= 4'h0;
		end else if (irq_ack || !irq_valid) begin
			irq_ack <= 1'b0;
			wait_ff <= 4'h0;
		end else if (wait_ff >= lat) begin
			irq_ack <= 1'b1;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule // via_core_model

// [verif/via_props.sv]
`timescale 1ns/1ns
// ********
// Arbiter port checker
// ********
module via_props (
	input wire ref_clk, // Core clock
	input wire rst, // Async reset
	input wire [3:0] avs_address, // Word address
	input wire avs_write, // Write strobe
	input wire [31:0] avs_writedata, // Write data
	input wire reset_req, // Reset request
	input wire irq_valid, // Request to core
	input wire [15:0] irq_vector, // Vector address
	input wire [3:0] irq_priority, // Presented priority
	input wire irq_ack, // Core accept
	input wire irq_out // Status interrupt
);
	reg glb_ff;
	reg [2:0] mask_ff;
	reg [3:0] cur_ff;
	wire evt = irq_vector >= 16'h0080 && irq_vector < 16'h0100;
	wire took = irq_valid && irq_ack;
	// Shadows of global enable, mask and running priority
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			glb_ff <= 1'b0;
			mask_ff <= 3'h0;
			cur_ff <= 4'h0;
		end else begin
			if (avs_write && avs_address == 4'h0)
				glb_ff <= avs_writedata[7];
			if (avs_write && avs_address == 4'hb)
				mask_ff <= avs_writedata[2:0];
			if (avs_write && avs_address == 4'h9)
				cur_ff <= avs_writedata[3:0];
			else if (took)
				cur_ff <= irq_priority;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	property p_align;
		irq_valid |-> irq_vector[1:0] == 2'b00;
	endproperty
	a_align: assert property (p_align) else $error("vector not word aligned");
	property p_evt_top;
		irq_valid && evt |-> irq_priority[3];
	endproperty
	a_evt_top: assert property (p_evt_top) else $error("event priority top bit low");
	property p_exc_pri;
		irq_valid && irq_vector < 16'h0080 |-> irq_priority == 4'hf;
	endproperty
	a_exc_pri: assert property (p_exc_pri) else $error("exception priority wrong");
	property p_swi_pri;
		irq_valid && irq_vector >= 16'h0100 |-> irq_priority == {1'b0, irq_vector[4:2] + 3'h1};
	endproperty
	a_swi_pri: assert property (p_swi_pri) else $error("soft priority wrong");
	property p_global;
		irq_valid && evt |-> $past(glb_ff);
	endproperty
	a_global: assert property (p_global) else $error("event with global off");
	property p_above;
		irq_valid && irq_vector >= 16'h0080 |-> irq_priority > $past(cur_ff);
	endproperty
	a_above: assert property (p_above) else $error("request not above running");
	property p_reset_vec;
		reset_req ##1 reset_req ##1 (reset_req && irq_valid) |-> irq_vector == 16'h0000;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("reset vector lost");
	property p_ack_drop;
		took |=> !irq_valid;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("valid held after take");
	property p_status;
		took && (mask_ff[0] && evt || mask_ff[2] && irq_vector >= 16'h0100) |=> irq_out;
	endproperty
	a_status: assert property (p_status) else $error("irq_out missing");
	c_rank: cover property (irq_valid && irq_vector == 16'h00ac);
	c_soft: cover property (irq_valid && irq_vector == 16'h0118);
	c_reset: cover property (took && irq_vector == 16'h0000);
endmodule // via_props
bind via_arbiter via_props u_via_props (.ref_clk(ref_clk), .rst(rst),
	.avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.reset_req(reset_req), .irq_valid(irq_valid), .irq_vector(irq_vector),
	.irq_priority(irq_priority), .irq_ack(irq_ack), .irq_out(irq_out));
